//--- src/gpib_camac_pkg.sv
package gpib_camac_pkg;

	// Clock rate and derived cycle counts
	localparam int CLK_MHZ     = 50;
	localparam int T_SETTLE_NS = 200;   // Data settle before DAV
	localparam int T_S1_DLY_NS = 500;   // Busy to S1
	localparam int T_STRB_NS   = 250;   // S1 and S2 width
	localparam int T_GAP_NS    = 125;   // S1 end to S2, S2 end to Busy end

	// Least times round up to whole cycles
	localparam int SETTLE_CYC = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int S1_ON      = (T_S1_DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int STRB_CYC   = (T_STRB_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYC    = (T_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int S1_OFF     = S1_ON + STRB_CYC;
	localparam int S2_ON      = S1_OFF + GAP_CYC;
	localparam int S2_OFF     = S2_ON + STRB_CYC;
	localparam int CYC_END    = S2_OFF + GAP_CYC;
	localparam int CNT_W      = 7;

	// Bus commands sent with ATN
	localparam logic [7:0] CMD_SPE  = 8'h18;
	localparam logic [7:0] CMD_SPD  = 8'h19;
	localparam logic [7:0] CMD_UNL  = 8'h3f;
	localparam logic [7:0] CMD_UNT  = 8'h5f;
	localparam logic [2:0] GRP_LSN  = 3'h1;  // Listen address group
	localparam logic [2:0] GRP_TLK  = 3'h2;  // Talk address group

	// First listen byte class in bits 7..6 (zero based 6..5)
	localparam logic [1:0] CLS_MOD  = 2'h0;
	localparam logic [1:0] CLS_GLB  = 2'h1;

	// Own setup field positions within bits 1..5
	localparam int SET_CNT_LO = 0;   // Read-back data byte count, 2 bits
	localparam int SET_BLK    = 2;   // Block mode enable
	localparam int SET_LAM    = 3;   // SRQ on any LAM
	localparam int SET_XQ     = 4;   // SRQ on X or Q zero
	// Global command bit positions
	localparam int GLB_C = 0;
	localparam int GLB_Z = 1;
	localparam int GLB_I = 2;

	// Latched read-back command, no dataway cycle
	localparam logic [4:0] LATCH_F = 5'h00;
	localparam logic [3:0] LATCH_A = 4'h0;
	localparam logic [4:0] LATCH_N = 5'h18;

	// Listen sequencer slots
	localparam logic [2:0] SEQ_FIRST = 3'h0;
	localparam logic [2:0] SEQ_A     = 3'h1;
	localparam logic [2:0] SEQ_N     = 3'h2;
	localparam logic [2:0] SEQ_W0    = 3'h3;
	localparam logic [2:0] SEQ_W1    = 3'h4;
	localparam logic [2:0] SEQ_W2    = 3'h5;
	localparam logic [2:0] SEQ_DONE  = 3'h6;

	localparam int         N_LAM     = 24;
	localparam int         SP_BYTES  = 5;   // X/Q byte then four LAM bytes
	localparam int         LAM_PER   = 6;
	localparam int         SRQ_BIT   = 6;   // Bit 7 of a status byte

	// Command decoder modes
	typedef enum logic [1:0] {
		MD_IDLE,
		MD_LISTEN,
		MD_TALK,
		MD_SPOLL
	} mode_t;

	// Dataway command held between cycles
	typedef struct packed {
		logic [4:0]  f;
		logic [3:0]  a;
		logic [4:0]  n;
		logic [23:0] w;
	} dw_cmd_t;

	// Talker FIFO word
	typedef struct packed {
		logic       eoi;
		logic [7:0] data;
	} tx_word_t;

endpackage : gpib_camac_pkg

//--- src/gpib_camac_bridge.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Talker byte FIFO

module tx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	// Wrap-bit pointers need a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
		$error("tx_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];   // Storage
	logic [AW:0]      wp_r;            // Write pointer with wrap bit
	logic [AW:0]      rp_r;            // Read pointer with wrap bit
	logic             push;
	logic             pop;

	// Full and empty from pointer compare
	assign in_ready  = !((wp_r[AW] != rp_r[AW]) &&
	                     (wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid = (wp_r != rp_r);
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;
	assign out_data  = mem_r[rp_r[AW-1:0]];

	// Pointers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (push)
			mem_r[wp_r[AW-1:0]] <= in_data;
	end

endmodule : tx_fifo

////////////////////////////////////////////////////////////////////////////////
// Instrument bus to crate dataway bridge

module gpib_camac_bridge #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic [4:0]  my_addr,    // Primary bus address
	input  wire logic        swap_bytes, // Swap first two read bytes
	input  wire logic        ifc,        // Interface clear, high true
	input  wire logic        atn,        // Attention, high true
	input  wire logic [7:0]  dio_in,     // Data lines in
	output logic      [7:0]  dio_out,    // Data lines out
	output logic             dio_oe,     // Drive data lines
	input  wire logic        dav_in,     // Data valid from talker
	output logic             dav_out,    // Data valid as talker
	output logic             eoi_out,    // End with last byte
	input  wire logic        rfd_in,     // Listener ready
	output logic             rfd_out,    // Ready as acceptor
	input  wire logic        dac_in,     // Listener accepted
	output logic             dac_out,    // Accepted as acceptor
	output logic             srq_out,    // Service request
	output logic             busy,       // Dataway Busy
	output logic             s1,         // Strobe 1
	output logic             s2,         // Strobe 2
	output gpib_camac_pkg::dw_cmd_t dw_cmd, // F, A, N, W lines
	output logic             dw_c,       // Clear line
	output logic             dw_z,       // Initialise line
	output logic             dw_i,       // Inhibit line
	input  wire logic [23:0] dw_r,       // Read lines
	input  wire logic        dw_x,       // Command accepted
	input  wire logic        dw_q,       // Response
	input  wire logic [23:0] lam         // LAM lines, slot 1 in bit 0
);
	// A whole status burst must fit the FIFO
	if (FIFO_DEPTH < gpib_camac_pkg::SP_BYTES) begin : g_bad_fifo
		$error("gpib_camac_bridge: FIFO too shallow for status");
	end

	////////////////////////////////////////////////////////////////////////
	// Declarations

	gpib_camac_pkg::mode_t   mode_r;     // Decoder state
	logic                    spas_r;     // Serial poll active flag
	logic                    sp_talk_r;  // Talking status bytes
	gpib_camac_pkg::dw_cmd_t cmd_r;      // Latched dataway command
	logic                    c_r, z_r, i_r;
	logic [1:0]              cnt_r;      // Read-back byte count
	logic                    blk_r;      // Block mode enable
	logic                    en_lam_r;   // SRQ on LAM
	logic                    en_xq_r;    // SRQ on X or Q zero
	logic [2:0]              seq_r;      // Listen sequencer slot
	logic                    dac_r;      // Acceptor accepted
	logic                    srq_r;      // Pending request
	logic [23:0]             rd_r;       // Latched read data
	logic                    x_r, q_r;   // Latched responses
	logic                    cyc_req_r;  // Cycle wanted
	logic                    busy_r;
	logic [gpib_camac_pkg::CNT_W-1:0] tmr_r;  // Cycle timer
	logic                    prod_r;     // Producer loading FIFO
	logic [2:0]              pidx_r;     // Producer byte index
	logic                    sp_pend_r;  // Status queued, awaiting read
	logic                    dav_r;
	logic                    eoi_r;
	logic [7:0]              dout_r;
	logic [3:0]              settle_r;   // DAV settle counter
	logic                    take;       // Acceptor captures a byte
	logic                    is_cmd;     // Captured byte is a command
	logic                    is_mla, is_mta;
	logic                    talk_act;   // Talker active
	logic                    special;    // Latched read-back command
	logic                    cyc_go;     // Cycle starts now
	logic                    s1_end;     // Read lines sampled now
	logic                    cyc_done;   // Cycle ends now
	logic [2:0]              plen;       // Bytes the producer sends
	gpib_camac_pkg::tx_word_t pw;        // Producer word
	logic                    f_rdy;
	gpib_camac_pkg::tx_word_t f_out;
	logic                    f_val;
	logic                    f_pop;
	logic                    push;
	logic                    tx_idle;    // Nothing queued or on the bus

	////////////////////////////////////////////////////////////////////////
	// Decode

	// Acceptor takes a byte once valid, gated by attention or listen
	assign take    = ce && dav_in && rfd_out && (atn || mode_r == gpib_camac_pkg::MD_LISTEN);
	assign is_cmd  = atn;
	assign is_mla  = dio_in[7:5] == gpib_camac_pkg::GRP_LSN && dio_in[4:0] == my_addr;
	assign is_mta  = dio_in[7:5] == gpib_camac_pkg::GRP_TLK && dio_in[4:0] == my_addr;
	assign talk_act = (mode_r == gpib_camac_pkg::MD_TALK) || sp_talk_r;
	assign special = cmd_r.f == gpib_camac_pkg::LATCH_F &&
	                 cmd_r.a == gpib_camac_pkg::LATCH_A &&
	                 cmd_r.n == gpib_camac_pkg::LATCH_N;
	assign cyc_go  = cyc_req_r && !busy_r && !srq_r && !special && !prod_r;
	assign s1_end  = busy_r && tmr_r == gpib_camac_pkg::CNT_W'(gpib_camac_pkg::S1_OFF);
	assign cyc_done = busy_r && tmr_r == gpib_camac_pkg::CNT_W'(gpib_camac_pkg::CYC_END);
	assign tx_idle = !f_val && !dav_r && !prod_r;

	////////////////////////////////////////////////////////////////////////
	// Command decoder

	// Mode transitions on bus commands
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc) begin
			mode_r    <= gpib_camac_pkg::MD_IDLE;
			spas_r    <= 1'b0;
			sp_talk_r <= 1'b0;
		end else if (take && is_cmd) begin
			if (dio_in == gpib_camac_pkg::CMD_SPE) begin
				spas_r <= 1'b1;
				mode_r <= gpib_camac_pkg::MD_SPOLL;
			end else if (dio_in == gpib_camac_pkg::CMD_SPD) begin
				spas_r    <= 1'b0;
				sp_talk_r <= 1'b0;
				if (mode_r == gpib_camac_pkg::MD_SPOLL)
					mode_r <= gpib_camac_pkg::MD_IDLE;
			end else if (is_mta) begin
				if (spas_r)
					sp_talk_r <= 1'b1;
				else
					mode_r <= gpib_camac_pkg::MD_TALK;
			end else if (dio_in == gpib_camac_pkg::CMD_UNT) begin
				sp_talk_r <= 1'b0;
				if (mode_r == gpib_camac_pkg::MD_TALK)
					mode_r <= gpib_camac_pkg::MD_IDLE;
			end else if (is_mla) begin
				mode_r <= gpib_camac_pkg::MD_LISTEN;
			end else if (dio_in == gpib_camac_pkg::CMD_UNL) begin
				if (mode_r == gpib_camac_pkg::MD_LISTEN)
					mode_r <= gpib_camac_pkg::MD_IDLE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acceptor handshake

	// Accepted held until the talker drops valid
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc)
			dac_r <= 1'b0;
		else if (take)
			dac_r <= 1'b1;
		else if (ce && !dav_in)
			dac_r <= 1'b0;
	end

	// Ready when not talking and no byte in hand
	assign rfd_out = !dac_r && !(talk_act && !atn);
	assign dac_out = dac_r;

	////////////////////////////////////////////////////////////////////////
	// Listen sequencer and latches

	// Byte sequencer, restarted by own listen address
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc)
			seq_r <= gpib_camac_pkg::SEQ_FIRST;
		else if (take && is_cmd && is_mla)
			seq_r <= gpib_camac_pkg::SEQ_FIRST;
		else if (take && !is_cmd) begin
			// Only a module byte opens the sequence
			if (seq_r == gpib_camac_pkg::SEQ_FIRST)
				seq_r <= (dio_in[6:5] == gpib_camac_pkg::CLS_MOD) ?
				         gpib_camac_pkg::SEQ_A : gpib_camac_pkg::SEQ_FIRST;
			else if (seq_r != gpib_camac_pkg::SEQ_DONE)
				seq_r <= seq_r + 3'h1;
		end
	end

	// F, A, N, W persist until overwritten
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc)
			cmd_r <= '0;
		else if (take && !is_cmd) begin
			case (seq_r)
				gpib_camac_pkg::SEQ_FIRST: begin
					if (dio_in[6:5] == gpib_camac_pkg::CLS_MOD)
						cmd_r.f <= dio_in[4:0];
				end
				gpib_camac_pkg::SEQ_A:  cmd_r.a        <= dio_in[3:0];
				gpib_camac_pkg::SEQ_N:  cmd_r.n        <= dio_in[4:0];
				gpib_camac_pkg::SEQ_W0: cmd_r.w[7:0]   <= dio_in;
				gpib_camac_pkg::SEQ_W1: cmd_r.w[15:8]  <= dio_in;
				gpib_camac_pkg::SEQ_W2: cmd_r.w[23:16] <= dio_in;
				default: ;
			endcase
		end
	end

	// Global command latches
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc) begin
			c_r <= 1'b0;
			z_r <= 1'b0;
			i_r <= 1'b0;
		end else if (take && !is_cmd && seq_r == gpib_camac_pkg::SEQ_FIRST &&
		             dio_in[6:5] == gpib_camac_pkg::CLS_GLB) begin
			c_r <= dio_in[gpib_camac_pkg::GLB_C];
			z_r <= dio_in[gpib_camac_pkg::GLB_Z];
			i_r <= dio_in[gpib_camac_pkg::GLB_I];
		end else if (ce && cyc_done) begin
			c_r <= 1'b0;
			z_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc) begin
			cnt_r    <= '0;
			blk_r    <= 1'b0;
			en_lam_r <= 1'b0;
			en_xq_r  <= 1'b0;
		end else if (take && !is_cmd && seq_r == gpib_camac_pkg::SEQ_FIRST &&
		             dio_in[6]) begin
			cnt_r    <= dio_in[gpib_camac_pkg::SET_CNT_LO +: 2];
			blk_r    <= dio_in[gpib_camac_pkg::SET_BLK];
			en_lam_r <= dio_in[gpib_camac_pkg::SET_LAM];
			en_xq_r  <= dio_in[gpib_camac_pkg::SET_XQ];
		end else if (ce && s1_end && !dw_q)
			blk_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Dataway cycle

	// Cycle request from talk address or block refill
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc)
			cyc_req_r <= 1'b0;
		else if (ce) begin
			if (take && is_cmd && is_mta && !spas_r)
				cyc_req_r <= 1'b1;
			else if (mode_r == gpib_camac_pkg::MD_TALK && blk_r && tx_idle &&
			         !busy_r && !cyc_req_r && !atn)
				cyc_req_r <= 1'b1;
			else if (cyc_go || special || mode_r != gpib_camac_pkg::MD_TALK)
				cyc_req_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc) begin
			busy_r <= 1'b0;
			tmr_r  <= '0;
		end else if (ce) begin
			if (cyc_go) begin
				busy_r <= 1'b1;
				tmr_r  <= '0;
			end else if (cyc_done)
				busy_r <= 1'b0;
			else if (busy_r)
				tmr_r <= tmr_r + 1'b1;
		end
	end

	// Latch read lines at end of S1
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc) begin
			rd_r <= '0;
			x_r  <= 1'b0;
			q_r  <= 1'b0;
		end else if (ce && s1_end) begin
			rd_r <= dw_r;
			x_r  <= dw_x;
			q_r  <= dw_q;
		end
	end

	assign busy = busy_r;
	assign s1 = busy_r && tmr_r >= gpib_camac_pkg::CNT_W'(gpib_camac_pkg::S1_ON) &&
	            tmr_r < gpib_camac_pkg::CNT_W'(gpib_camac_pkg::S1_OFF);
	assign s2 = busy_r && tmr_r >= gpib_camac_pkg::CNT_W'(gpib_camac_pkg::S2_ON) &&
	            tmr_r < gpib_camac_pkg::CNT_W'(gpib_camac_pkg::S2_OFF);
	assign dw_cmd = busy_r ? cmd_r : '0;
	assign dw_c = busy_r && c_r;
	assign dw_z = busy_r && z_r;
	assign dw_i = busy_r && i_r;

	////////////////////////////////////////////////////////////////////////
	// Service request

	// Set on LAM or X/Q zero; set wins over clear
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc)
			srq_r <= 1'b0;
		else if (ce && ((en_lam_r && |lam) ||
		         (en_xq_r && s1_end && (!dw_x || !dw_q))))
			srq_r <= 1'b1;
		else if (take && is_cmd && dio_in == gpib_camac_pkg::CMD_SPD)
			srq_r <= 1'b0;
		else if (ce && sp_pend_r && tx_idle)
			srq_r <= 1'b0;
	end
	assign srq_out = srq_r;

	////////////////////////////////////////////////////////////////////////
	// Output producer

	// Number of bytes in this burst
	always_comb begin
		if (sp_talk_r)
			plen = 3'(gpib_camac_pkg::SP_BYTES);
		else
			plen = {1'b0, cnt_r} + {2'b00, !blk_r};
	end

	// Select the byte for the current index
	always_comb begin
		pw = '0;
		if (sp_talk_r) begin
			// Status bytes, bit 7 shows SRQ
			pw.data[gpib_camac_pkg::SRQ_BIT] = srq_r;
			if (pidx_r == 3'h0)
				pw.data[1:0] = {q_r, x_r};
			else
				pw.data[5:0] = lam[(32'(pidx_r) - 1) * gpib_camac_pkg::LAM_PER +: 6];
			pw.eoi = pidx_r == plen - 3'h1;
		end else if (pidx_r < {1'b0, cnt_r}) begin
			// Optional swap of first two bytes
			case (pidx_r)
				3'h0:    pw.data = swap_bytes ? rd_r[15:8] : rd_r[7:0];
				3'h1:    pw.data = swap_bytes ? rd_r[7:0] : rd_r[15:8];
				default: pw.data = rd_r[23:16];
			endcase
		end else begin
			pw.data[1:0] = {q_r, x_r};
			pw.eoi       = 1'b1;
		end
	end

	assign push = prod_r && f_rdy && ce;

	// Producer start and advance
	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc) begin
			prod_r    <= 1'b0;
			pidx_r    <= '0;
			sp_pend_r <= 1'b0;
		end else if (ce) begin
			if (!prod_r) begin
				pidx_r <= '0;
				if (take && is_cmd && is_mta && spas_r)
					prod_r <= 1'b1;
				else if ((cyc_done || (cyc_req_r && special && !busy_r)) &&
				         mode_r == gpib_camac_pkg::MD_TALK && plen != 3'h0)
					prod_r <= 1'b1;
				if (sp_pend_r && tx_idle)
					sp_pend_r <= 1'b0;
			end else if (push) begin
				pidx_r <= pidx_r + 3'h1;
				if (pidx_r == plen - 3'h1) begin
					prod_r    <= 1'b0;
					sp_pend_r <= sp_talk_r;
				end
			end
		end
	end

	tx_fifo #(
		.WIDTH ($bits(gpib_camac_pkg::tx_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst && !ifc),
		.ce        (ce),
		.in_data   (pw),
		.in_valid  (prod_r),
		.in_ready  (f_rdy),
		.out_data  (f_out),
		.out_valid (f_val),
		.out_ready (f_pop)
	);

	////////////////////////////////////////////////////////////////////////
	// Source handshake

	// Accepted drops DAV and pops the byte
	assign f_pop = dav_r && dac_in;

	always_ff @(posedge clk_sys) begin
		if (!nrst || ifc) begin
			dav_r    <= 1'b0;
			eoi_r    <= 1'b0;
			dout_r   <= '0;
			settle_r <= '0;
		end else if (ce) begin
			if (dav_r) begin
				if (dac_in) begin
					dav_r <= 1'b0;
					eoi_r <= 1'b0;
				end
			end else if (talk_act && !atn && rfd_in && f_val && !dac_in) begin
				dout_r <= f_out.data;
				if (settle_r == 4'(gpib_camac_pkg::SETTLE_CYC)) begin
					dav_r    <= 1'b1;
					eoi_r    <= f_out.eoi;
					settle_r <= '0;
				end else
					settle_r <= settle_r + 4'h1;
			end else
				settle_r <= '0;
		end
	end

	// Bus buffers turn round while talking
	assign dio_oe  = talk_act && !atn;
	assign dio_out = dout_r;
	assign dav_out = dav_r;
	assign eoi_out = eoi_r;

endmodule : gpib_camac_bridge

//--- sim/camac_module_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Crate module: answers while Busy, scrambles its lines otherwise
module camac_module_model #(
	parameter logic [23:0] MASK = 24'ha5c3e1  // Read data is write data ^ mask
) (
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	input  wire logic                    busy,
	input  wire gpib_camac_pkg::dw_cmd_t dw_cmd,
	input  wire logic                    q_en,
	output logic                  [23:0] dw_r,
	output logic                         dw_x,
	output logic                         dw_q
);
	// Released lines toggle so a stale value is never latched by luck
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dw_r <= 24'h000000;
			dw_x <= 1'b0;
			dw_q <= 1'b0;
		end else if (busy) begin
			dw_r <= dw_cmd.w ^ MASK;
			dw_x <= 1'b1;
			dw_q <= q_en;
		end else begin
			dw_r <= ~dw_r;
			dw_x <= ~dw_x;
			dw_q <= ~dw_q;
		end
	end
endmodule : camac_module_model

//--- sim/gpib_camac_bridge_monitor.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Handshake and cycle timing checks on the bridge pins
module gpib_camac_bridge_monitor (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic ifc,
	input wire logic atn,
	input wire logic dio_oe,
	input wire logic dav_in,
	input wire logic dav_out,
	input wire logic eoi_out,
	input wire logic rfd_out,
	input wire logic dac_in,
	input wire logic dac_out,
	input wire logic srq_out,
	input wire logic busy,
	input wire logic s1,
	input wire logic s2
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst || ifc || !ce);

	// Strobe windows: S1 counted from Busy rising, S2 from S1 falling
	sequence s1_strobe;
		##25 $rose(s1) ##13 $fell(s1);
	endsequence
	sequence s2_strobe;
		##7 $rose(s2) ##13 $fell(s2);
	endsequence

	a_accept_ack: assert property (
		dav_in && rfd_out && atn |=> dac_out) else $error("no accept");
	a_ack_drop: assert property (
		dac_out && !dav_in |=> !dac_out) else $error("accept stuck");
	a_dav_settle: assert property (
		$rose(dav_out) |-> $past(dio_oe) && $past(dio_oe, 10))
		else $error("valid too early");
	a_dav_release: assert property (
		dav_out && dac_in |=> !dav_out) else $error("valid stuck");
	a_eoi_dav: assert property (
		eoi_out |-> dav_out) else $error("end without valid");
	a_oe_no_atn: assert property (
		dio_oe |-> !atn) else $error("driving under attention");
	a_cycle_shape: assert property (
		$rose(busy) |-> (busy throughout
		(s1_strobe ##0 s2_strobe ##7 1'b1)) ##1 $fell(busy))
		else $error("cycle timing");
	a_srq_hold: assert property (
		$past(srq_out) && srq_out |-> !$rose(busy))
		else $error("cycle while request pending");
endmodule : gpib_camac_bridge_monitor

bind gpib_camac_bridge gpib_camac_bridge_monitor gpib_camac_bridge_monitor_inst (
	.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .ifc(ifc), .atn(atn),
	.dio_oe(dio_oe), .dav_in(dav_in), .dav_out(dav_out),
	.eoi_out(eoi_out), .rfd_out(rfd_out), .dac_in(dac_in),
	.dac_out(dac_out), .srq_out(srq_out), .busy(busy), .s1(s1), .s2(s2)
);

//--- sim/test_gpib_camac_bridge.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Bench: bus controller tasks against the bridge and a crate module
module test_gpib_camac_bridge;
	localparam logic [4:0]  ADDR = 5'h07;         // Own bus address
	localparam logic [23:0] K    = 24'ha5c3e1;    // Module read mask
	localparam logic [23:0] KS   = {K[23:16], K[7:0], K[15:8]}; // Swapped
	logic                    clk_sys = 1'b0;
	logic                    nrst    = 1'b0;
	logic                    ifc     = 1'b0;
	logic                    atn     = 1'b0;
	logic                    dav_in  = 1'b0;
	logic                    rfd_in  = 1'b0;
	logic                    dac_in  = 1'b0;
	logic                    q_en    = 1'b1;
	logic                    swap    = 1'b0;      // Read byte swap setting
	logic                    zc      = 1'b0;      // Z line seen in Busy
	logic [7:0]              dio_in  = 8'h00;
	logic [23:0]             lam     = 24'h820041;
	logic [39:0]             cap     = 40'h0;     // C, I, F/A/N/W in Busy
	logic [7:0]              dio_out;
	logic                    dio_oe, dav_out, eoi_out, rfd_out, dac_out;
	logic                    srq_out, busy, s1, s2, dw_c, dw_i, dw_x, dw_q;
	logic                    dw_z;
	logic [23:0]             dw_r;
	gpib_camac_pkg::dw_cmd_t dw_cmd;
	int                      busy_cnt = 0;
	int                      err_count = 0;
	int                      tests_run = 0;

	gpib_camac_bridge gpib_camac_bridge_inst (
		.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .my_addr(ADDR),
		.swap_bytes(swap), .ifc(ifc), .atn(atn), .dio_in(dio_in),
		.dio_out(dio_out), .dio_oe(dio_oe), .dav_in(dav_in),
		.dav_out(dav_out), .eoi_out(eoi_out), .rfd_in(rfd_in),
		.rfd_out(rfd_out), .dac_in(dac_in), .dac_out(dac_out),
		.srq_out(srq_out), .busy(busy), .s1(s1), .s2(s2), .dw_cmd(dw_cmd),
		.dw_c(dw_c), .dw_z(dw_z), .dw_i(dw_i), .dw_r(dw_r), .dw_x(dw_x),
		.dw_q(dw_q), .lam(lam)
	);
	camac_module_model #(.MASK(K)) camac_module_model_inst (
		.clk_sys(clk_sys), .nrst(nrst), .busy(busy), .dw_cmd(dw_cmd),
		.q_en(q_en), .dw_r(dw_r), .dw_x(dw_x), .dw_q(dw_q)
	);

	always #10 clk_sys = ~clk_sys;

	// Count clocks with Busy high and keep the dataway lines, sampled mid-cycle
	always @(negedge clk_sys) begin
		if (busy === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
			cap <= {dw_c, dw_i, dw_cmd};
			zc <= dw_z;
		end
	end

	task automatic chk(input string nm, input logic [39:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Attention first, then valid held until accepted, then release
	task automatic put(input logic a, input logic [7:0] b);
		int i;
		i = 0;
		@(posedge clk_sys) #1 atn = a;
		do @(posedge clk_sys) #1; while (rfd_out !== 1'b1 && ++i < 50);
		dio_in = b;
		dav_in = 1'b1;
		do @(posedge clk_sys) #1; while (dac_out !== 1'b1 && ++i < 50);
		dav_in = 1'b0;
		dio_in = ~b;
		atn = 1'b0;
		do @(posedge clk_sys) #1; while (dac_out !== 1'b0 && ++i < 50);
		chk("accept stall", 40'h0, 40'(i >= 50));
	endtask : put

	// Ready, wait for valid, accept, release after valid drops
	task automatic get(input logic [7:0] b, input logic e);
		int i;
		i = 0;
		@(posedge clk_sys) #1 rfd_in = 1'b1;
		do @(posedge clk_sys) #1; while (dav_out !== 1'b1 && ++i < 300);
		chk("byte", 40'(b), 40'(dio_out));
		chk("end", 40'(e), 40'(eoi_out));
		dac_in = 1'b1;
		rfd_in = 1'b0;
		do @(posedge clk_sys) #1; while (dav_out !== 1'b0 && ++i < 300);
		dac_in = 1'b0;
		chk("source stall", 40'h0, 40'(i >= 300));
	endtask : get

	task automatic listen(input logic [47:0] bs, input int n);
		int k;
		put(1'b1, {3'h1, ADDR});
		for (k = 0; k < n; k++) put(1'b0, bs[8*k+:8]);
		put(1'b1, 8'h3f);
	endtask : listen

	task automatic talk(input int n, input logic [23:0] d,
			input logic [7:0] xq, input int cyc);
		int b;
		int k;
		b = busy_cnt;
		put(1'b1, {3'h2, ADDR});
		for (k = 0; k < n; k++) get(d[8*k+:8], 1'b0);
		get(xq, 1'b1);
		put(1'b1, 8'h5f);
		chk("busy cycles", 40'(cyc), 40'(busy_cnt - b));
	endtask : talk

	task automatic wrap_up();
		if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	initial begin
		#200000 err_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		int k;
		repeat (16) @(posedge clk_sys);
		#1 nrst = 1'b1;
		chk("idle", 40'h8, {rfd_out, dav_out, srq_out, busy});
		listen(48'h53, 1);
		listen(48'h332211050310, 6);
		talk(3, 24'h332211 ^ K, 8'h03, 66);
		chk("cmd", {2'h0, 14'h2065, 24'h332211}, cap);
		listen(48'h180000, 3);
		talk(3, 24'h332211 ^ K, 8'h03, 0);
		swap = 1'b1;
		talk(3, 24'h331122 ^ KS, 8'h03, 0);
		swap = 1'b0;
		listen(48'h27, 1);
		listen(48'h10, 1);
		q_en = 1'b0;
		talk(3, 24'h332211 ^ K, 8'h01, 66);
		chk("c i f a n w", {2'h3, 14'h2018, 24'h332211}, cap);
		chk("z", 40'h1, 40'(zc));
		chk("srq", 40'h1, 40'(srq_out));
		put(1'b1, 8'h18);
		put(1'b1, {3'h2, ADDR});
		get(8'h41, 1'b0);
		for (k = 0; k < 4; k++) get(8'h40 | lam[6*k+:6], k == 3);
		put(1'b1, 8'h5f);
		chk("srq", 40'h0, 40'(srq_out));
		put(1'b1, 8'h19);
		q_en = 1'b1;
		talk(3, 24'h332211 ^ K, 8'h03, 66);
		chk("c i", 40'h1, 40'(cap[39:38]));
		chk("z", 40'h0, 40'(zc));
		listen(48'h5b, 1);
		chk("srq", 40'h1, 40'(srq_out));
		put(1'b1, 8'h19);
		chk("srq", 40'h1, 40'(srq_out));
		@(posedge clk_sys) #1 ifc = 1'b1;
		@(posedge clk_sys) #1 ifc = 1'b0;
		chk("idle", 40'h8, {rfd_out, dav_out, srq_out, busy});
		talk(0, 24'h0, 8'h03, 66);
		chk("c i", 40'h0, 40'(cap[39:38]));
		wrap_up();
	end
endmodule : test_gpib_camac_bridge
